// *** ccu_pkg.sv ***
// Shared constants and types for the counter compare output unit
package ccu_pkg;
  // ==========================================
  // Register map (index on the register port)
  localparam logic [2:0] CCU_ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] CCU_ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] CCU_ADDR_COUNT = 3'h2;
  localparam logic [2:0] CCU_ADDR_CMP_A = 3'h3;
  localparam logic [2:0] CCU_ADDR_CMP_B = 3'h4;
  localparam logic [2:0] CCU_ADDR_FLAGS = 3'h5;
  localparam logic [2:0] CCU_ADDR_IRQ_EN = 3'h6;

  // ==========================================
  // Field positions
  localparam int CCU_CA_ACT_A = 6;
  localparam int CCU_CA_ACT_B = 4;
  localparam int CCU_CA_WM = 0;
  localparam int CCU_CB_FORCE_A = 7;
  localparam int CCU_CB_FORCE_B = 6;
  localparam int CCU_CB_WM2 = 3;
  localparam int CCU_CB_CS = 0;
  localparam int CCU_FL_OVF = 0;
  localparam int CCU_FL_CMP_A = 1;
  localparam int CCU_FL_CMP_B = 2;

  // ==========================================
  // Reset values and counter limits
  localparam logic [7:0] CCU_RESET_BYTE = 8'h00;
  localparam logic [7:0] CCU_BOTTOM = 8'h00;
  localparam logic [7:0] CCU_MAX = 8'hFF;

  // ==========================================
  // Prescaler divide counts
  localparam logic [9:0] CCU_DIV_8 = 10'h007;
  localparam logic [9:0] CCU_DIV_64 = 10'h03F;
  localparam logic [9:0] CCU_DIV_256 = 10'h0FF;
  localparam logic [9:0] CCU_DIV_1024 = 10'h3FF;

  // ==========================================
  // Waveform modes
  localparam logic [2:0] CCU_WM_NORMAL = 3'h0;
  localparam logic [2:0] CCU_WM_PC_MAX = 3'h1;
  localparam logic [2:0] CCU_WM_CTC = 3'h2;
  localparam logic [2:0] CCU_WM_FAST_MAX = 3'h3;
  localparam logic [2:0] CCU_WM_PC_CMP = 3'h5;
  localparam logic [2:0] CCU_WM_FAST_CMP = 3'h7;

  // Output actions
  localparam logic [1:0] CCU_ACT_NONE = 2'h0;
  localparam logic [1:0] CCU_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] CCU_ACT_CLEAR = 2'h2;
  localparam logic [1:0] CCU_ACT_SET = 2'h3;

  typedef enum logic [1:0] {
    CCU_SEQ_UP,
    CCU_SEQ_FAST,
    CCU_SEQ_PHASE
  } ccu_seq_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccu_bus_type;
endpackage

// *** ccu_counter_compare_unit.sv ***
// Eight-bit timer with two compare channels and pin override
// Contract
// RULE_01: clock_select picks the tick source; zero stops the counter.
// RULE_02: each tick clears, increments or decrements counter per mode.
// RULE_03: software may read and write counter_value at any time.
// RULE_04: a counter write beats a same-cycle clear or count.
// RULE_05: waveform_mode bits 1:0 in control A, bit 2 in control B.
// RULE_06: overflow_flag set at the mode's point and can raise interrupt.
// RULE_07: counter compared with both compare values by 8-bit equality.
// RULE_08: an equality sets the channel compare_flag on the next tick.
// RULE_09: compare_flag with its enable raises a compare interrupt request.
// RULE_10: flag cleared on interrupt service or by writing one.
// RULE_11: compare values double buffered in PWM modes only.
// RULE_12: buffered value moves to active only at top or bottom.
// RULE_13: compare access goes to buffer when buffered, else active.
// RULE_14: force_compare in non-PWM modes acts on output only.
// RULE_15: counter write blocks every match in the next tick.
// RULE_16: output_action change acts at the next match, unbuffered.
// RULE_17: reset clears each wave_output register.
// RULE_18: nonzero output_action drives pin from wave_output; direction gates.
// RULE_19: pin override depends on output_action only, not the mode.
// RULE_20: output_action zero leaves wave_output unchanged on a match.
// RULE_21: wave_output kept when the waveform mode changes.
// RULE_22: software avoids blocked-match writes and presets wave_output.
// RULE_23: bottom is 0x00 and maximum is 0xFF.
`timescale 1ns/1ps
module ccu_counter_compare_unit
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire ccu_bus_type bus,
  output logic [7:0] rdata,
  // External count input, falling or rising edge
  input wire logic ext_count_in,
  // Interrupt requests and service acknowledges
  output logic irq_overflow,
  output logic irq_compare_a,
  output logic irq_compare_b,
  input wire logic irq_ack_overflow,
  input wire logic irq_ack_compare_a,
  input wire logic irq_ack_compare_b,
  // Port pins
  input wire logic [1:0] port_data,
  input wire logic [1:0] wave_pin_direction,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);
  // ==========================================
  // Registers
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] counter_value;
  logic [7:0] cmp_active [2];
  logic [7:0] cmp_buffer [2];
  logic [2:0] flags;
  logic [2:0] irq_en;
  logic [1:0] wave_output;
  logic [9:0] prescale;
  logic ext_prev;
  logic count_down;
  logic block_match;

  logic [2:0] waveform_mode;
  logic [2:0] clock_select;
  logic [1:0] output_action [2];
  logic timer_tick;
  logic double_buffered;
  logic pwm_mode;
  ccu_seq_type seq;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic [1:0] match;
  logic [1:0] match_hit;
  logic count_write;
  logic [1:0] force_hit;
  logic ovf_event;
  logic db_update;
  logic wrap_to_bottom;
  logic [7:0] next_counter;
  logic next_down;

  assign count_write = bus.wr && bus.addr == CCU_ADDR_COUNT;
  // Mode split over both control registers
  // RULE_05 mode field assembly
  assign waveform_mode = {ctrl_b[CCU_CB_WM2], ctrl_a[CCU_CA_WM +: 2]};
  assign clock_select = ctrl_b[CCU_CB_CS +: 3];
  assign output_action[0] = ctrl_a[CCU_CA_ACT_A +: 2];
  assign output_action[1] = ctrl_a[CCU_CA_ACT_B +: 2];

  // ==========================================
  // Tick selection
  // RULE_01 source select, zero stops
  always_comb begin
    unique case (clock_select)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = (prescale[2:0] == CCU_DIV_8[2:0]);
      3'h3: timer_tick = (prescale[5:0] == CCU_DIV_64[5:0]);
      3'h4: timer_tick = (prescale[7:0] == CCU_DIV_256[7:0]);
      3'h5: timer_tick = (prescale == CCU_DIV_1024);
      3'h6: timer_tick = ext_prev && !ext_count_in;
      3'h7: timer_tick = !ext_prev && ext_count_in;
    endcase
  end

  // Free running so a new divide ratio needs no restart
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= 10'h000;
      ext_prev <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      ext_prev <= ext_count_in;
    end
  end

  // ==========================================
  // Sequence decode; reserved modes count like normal
  always_comb begin
    unique case (waveform_mode)
      CCU_WM_PC_MAX, CCU_WM_PC_CMP: seq = CCU_SEQ_PHASE;
      CCU_WM_FAST_MAX, CCU_WM_FAST_CMP: seq = CCU_SEQ_FAST;
      default: seq = CCU_SEQ_UP;
    endcase
  end

  assign pwm_mode = (seq != CCU_SEQ_UP);
  // RULE_11 buffering only in PWM modes
  assign double_buffered = pwm_mode;
  assign top = (waveform_mode == CCU_WM_CTC ||
    waveform_mode == CCU_WM_PC_CMP || waveform_mode == CCU_WM_FAST_CMP) ?
    cmp_active[0] : CCU_MAX;
  // RULE_23 fixed extremes
  assign at_top = (counter_value == top);
  assign at_bottom = (counter_value == CCU_BOTTOM);
  assign wrap_to_bottom = (seq == CCU_SEQ_FAST || waveform_mode ==
    CCU_WM_CTC) ? at_top : (seq == CCU_SEQ_UP && counter_value == CCU_MAX);

  // ==========================================
  // Next counter value
  // RULE_02 clear, increment or decrement
  always_comb begin
    next_counter = counter_value;
    next_down = count_down;
    if (timer_tick) begin
      unique case (seq)
        CCU_SEQ_PHASE: begin
          if (at_top) begin
            next_down = 1'b1;
          end else if (at_bottom) begin
            next_down = 1'b0;
          end
          next_counter = next_down ? counter_value - 8'h01 :
            counter_value + 8'h01;
        end
        default: begin
          next_down = 1'b0;
          next_counter = wrap_to_bottom ? CCU_BOTTOM :
            counter_value + 8'h01;
        end
      endcase
    end
  end

  // RULE_03 access at any time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_value <= CCU_RESET_BYTE;
      count_down <= 1'b0;
    end else begin
      count_down <= next_down;
      // RULE_04 write beats count
      if (count_write) begin
        counter_value <= bus.wdata;
      end else begin
        counter_value <= next_counter;
      end
    end
  end

  // Held until a tick consumes it, so it also spans a stopped timer
  // RULE_15 block latch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      block_match <= 1'b0;
    end else if (count_write) begin
      block_match <= 1'b1;
    end else if (timer_tick) begin
      block_match <= 1'b0;
    end
  end

  // ==========================================
  // Compare channels
  // Clear-on-match overflows at the FF to 00 wrap, not at its own top
  assign ovf_event = timer_tick &&
    ((seq == CCU_SEQ_PHASE) ? at_bottom : (seq == CCU_SEQ_FAST) ? at_top :
    (counter_value == CCU_MAX));
  assign db_update = timer_tick && double_buffered &&
    ((seq == CCU_SEQ_PHASE) ? at_top : at_top);

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [1:0] act;
    logic next_wave;
    assign act = output_action[ch];
    // RULE_07 equality comparator
    assign match[ch] = (counter_value == cmp_active[ch]);
    // RULE_15 blocked match
    assign match_hit[ch] = timer_tick && match[ch] && !block_match;
    assign force_hit[ch] = bus.wr && bus.addr == CCU_ADDR_CTRL_B &&
      bus.wdata[ch == 0 ? CCU_CB_FORCE_A : CCU_CB_FORCE_B] && !pwm_mode;

    // RULE_12 transfer at top
    // RULE_13 routed compare writes
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cmp_active[ch] <= CCU_RESET_BYTE;
        cmp_buffer[ch] <= CCU_RESET_BYTE;
      end else begin
        if (bus.wr && bus.addr == (ch == 0 ? CCU_ADDR_CMP_A :
            CCU_ADDR_CMP_B)) begin
          cmp_buffer[ch] <= bus.wdata;
          if (!double_buffered) begin
            cmp_active[ch] <= bus.wdata;
          end
        end
        if (db_update) begin
          cmp_active[ch] <= cmp_buffer[ch];
        end
      end
    end

    // Output action per mode; zero is always no action
    // RULE_16 action read live
    // RULE_20 zero holds output
    always_comb begin
      next_wave = wave_output[ch];
      if (match_hit[ch] || force_hit[ch]) begin
        unique case (act)
          CCU_ACT_NONE: next_wave = wave_output[ch];
          CCU_ACT_TOGGLE: begin
            if (!pwm_mode || (ch == 0 && waveform_mode[2])) begin
              next_wave = !wave_output[ch];
            end
          end
          CCU_ACT_CLEAR: next_wave = (seq == CCU_SEQ_PHASE) && count_down;
          CCU_ACT_SET: next_wave = !((seq == CCU_SEQ_PHASE) && count_down);
        endcase
      end else if (seq == CCU_SEQ_FAST && timer_tick && at_top) begin
        if (act == CCU_ACT_CLEAR) begin
          next_wave = 1'b1;
        end else if (act == CCU_ACT_SET) begin
          next_wave = 1'b0;
        end
      end
    end

    // RULE_14 forced action
    // RULE_17 reset to zero
    // RULE_21 no reset on mode change
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        wave_output[ch] <= 1'b0;
      end else begin
        wave_output[ch] <= next_wave;
      end
    end

    // RULE_18 override and direction
    // RULE_19 mode independent
    assign pin_out[ch] = (act != CCU_ACT_NONE) ? wave_output[ch] :
      port_data[ch];
    assign pin_oe[ch] = wave_pin_direction[ch];
  end

  // ==========================================
  // Flags: a set wins over any clear in the same cycle
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic flag_write;

  assign flag_write = bus.wr && bus.addr == CCU_ADDR_FLAGS;
  assign flag_set = {match_hit, ovf_event};
  assign flag_clr = ({3{flag_write}} & bus.wdata[2:0]) |
    {irq_ack_compare_b, irq_ack_compare_a, irq_ack_overflow};

  // RULE_06 overflow point
  // RULE_08 flag on tick
  // RULE_10 service or write one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= 3'h0;
    end else begin
      flags <= flag_set | (flags & ~flag_clr);
    end
  end

  // RULE_09 flag and enable
  assign irq_overflow = flags[CCU_FL_OVF] && irq_en[CCU_FL_OVF];
  assign irq_compare_a = flags[CCU_FL_CMP_A] && irq_en[CCU_FL_CMP_A];
  assign irq_compare_b = flags[CCU_FL_CMP_B] && irq_en[CCU_FL_CMP_B];

  // ==========================================
  // Control registers; force bits are strobes and read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a <= CCU_RESET_BYTE;
      ctrl_b <= CCU_RESET_BYTE;
      irq_en <= 3'h0;
    end else if (bus.wr) begin
      if (bus.addr == CCU_ADDR_CTRL_A) begin
        ctrl_a <= {bus.wdata[7:4], 2'h0, bus.wdata[1:0]};
      end
      if (bus.addr == CCU_ADDR_CTRL_B) begin
        ctrl_b <= {4'h0, bus.wdata[3:0]};
      end
      if (bus.addr == CCU_ADDR_IRQ_EN) begin
        irq_en <= bus.wdata[2:0];
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        CCU_ADDR_CTRL_A: rdata <= ctrl_a;
        CCU_ADDR_CTRL_B: rdata <= ctrl_b;
        CCU_ADDR_COUNT: rdata <= counter_value;
        CCU_ADDR_CMP_A: rdata <= double_buffered ? cmp_buffer[0] :
          cmp_active[0];
        CCU_ADDR_CMP_B: rdata <= double_buffered ? cmp_buffer[1] :
          cmp_active[1];
        CCU_ADDR_FLAGS: rdata <= {5'h00, flags};
        CCU_ADDR_IRQ_EN: rdata <= {5'h00, irq_en};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================
  // Checks
  sequence s_write_count;
    bus.wr && bus.addr == CCU_ADDR_COUNT;
  endsequence

  property p_stopped;
    @(posedge clk) disable iff (!reset_n)
    clock_select == 3'h0 && !count_write |=> $stable(counter_value);
  endproperty
  a_stopped: assert property (p_stopped) // RULE_01
    else $error("counter moved while stopped");

  property p_write_wins;
    @(posedge clk) disable iff (!reset_n)
    s_write_count |=> counter_value == $past(bus.wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) // RULE_04
    else $error("counter write lost");

  // Write seen and no tick since, kept apart from the design's latch
  logic chk_pend;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_pend <= 1'b0;
    end else if (count_write) begin
      chk_pend <= 1'b1;
    end else if (timer_tick) begin
      chk_pend <= 1'b0;
    end
  end

  property p_block;
    @(posedge clk) disable iff (!reset_n)
    chk_pend && timer_tick |=>
      !$rose(flags[CCU_FL_CMP_A]) && !$rose(flags[CCU_FL_CMP_B]);
  endproperty
  a_block: assert property (p_block) // RULE_15
    else $error("match not blocked after write");

  property p_flag_set;
    @(posedge clk) disable iff (!reset_n)
    match_hit[0] |=> flags[CCU_FL_CMP_A];
  endproperty
  a_flag_set: assert property (p_flag_set) // RULE_08
    else $error("compare flag not set");

  property p_irq;
    @(posedge clk) disable iff (!reset_n)
    flags[CCU_FL_CMP_B] && irq_en[CCU_FL_CMP_B] |-> irq_compare_b;
  endproperty
  a_irq: assert property (p_irq) // RULE_09
    else $error("compare interrupt missing");

  property p_clear_ack;
    @(posedge clk) disable iff (!reset_n)
    irq_ack_compare_a && !match_hit[0] |=> !flags[CCU_FL_CMP_A];
  endproperty
  a_clear_ack: assert property (p_clear_ack) // RULE_10
    else $error("flag not cleared on service");

  property p_force_no_flag;
    @(posedge clk) disable iff (!reset_n)
    force_hit[1] && !match_hit[1] && !flags[CCU_FL_CMP_B] &&
      !irq_ack_compare_b |=> !flags[CCU_FL_CMP_B];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) // RULE_14
    else $error("force set a flag");

  property p_zero_action;
    @(posedge clk) disable iff (!reset_n)
    output_action[0] == CCU_ACT_NONE |=> $stable(wave_output[0]);
  endproperty
  a_zero_action: assert property (p_zero_action) // RULE_20
    else $error("output changed with no action");

  property p_direct_cmp;
    @(posedge clk) disable iff (!reset_n)
    !double_buffered && bus.wr && bus.addr == CCU_ADDR_CMP_A
      |=> cmp_active[0] == $past(bus.wdata);
  endproperty
  a_direct_cmp: assert property (p_direct_cmp) // RULE_13
    else $error("direct compare write lost");

  property p_override;
    @(posedge clk) disable iff (!reset_n)
    output_action[1] != CCU_ACT_NONE |-> pin_out[1] == wave_output[1];
  endproperty
  a_override: assert property (p_override) // RULE_18
    else $error("pin not overridden");
endmodule

// *** ccu_counter_compare_unit_tb.sv ***
// Self-checking bench for the counter compare output unit
`timescale 1ns/1ps
module ccu_counter_compare_unit_tb import ccu_pkg::*;;
  // ==========================================
  // Design signals
  logic clk;
  logic reset_n;
  ccu_bus_type bus;
  logic [7:0] rdata;
  logic ext_count_in;
  logic irq_overflow;
  logic irq_compare_a;
  logic irq_compare_b;
  logic irq_ack_overflow;
  logic irq_ack_compare_a;
  logic irq_ack_compare_b;
  logic [1:0] port_data;
  logic [1:0] wave_pin_direction;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  int errors;
  int compares;
  logic [7:0] v;

  ccu_counter_compare_unit dut_u (
    .clk(clk),
    .reset_n(reset_n),
    .bus(bus),
    .rdata(rdata),
    .ext_count_in(ext_count_in),
    .irq_overflow(irq_overflow),
    .irq_compare_a(irq_compare_a),
    .irq_compare_b(irq_compare_b),
    .irq_ack_overflow(irq_ack_overflow),
    .irq_ack_compare_a(irq_ack_compare_a),
    .irq_ack_compare_b(irq_ack_compare_b),
    .port_data(port_data),
    .wave_pin_direction(wave_pin_direction),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // ==========================================
  // Helpers
  task automatic stop_test;
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ends on the edge that takes the write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask

  // Bounded wait so a dead flag cannot hang the run
  task automatic wait_irq(input int which, input int limit);
    for (int i = 0; i < limit; i++) begin
      @(posedge clk);
      #1;
      if (which == 0 && irq_overflow === 1'b1) break;
      if (which == 1 && irq_compare_b === 1'b1) break;
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), v);
      chk_byte(v, 8'h00);
    end
    chk_byte({6'h00, pin_out}, {6'h00, port_data});
    chk_byte({6'h00, pin_oe}, {6'h00, wave_pin_direction});
  endtask

  task automatic t_count;
    wr(CCU_ADDR_COUNT, 8'h10);
    repeat (5) @(posedge clk);
    rd(CCU_ADDR_COUNT, v);
    chk_byte(v, 8'h10);
    wr(CCU_ADDR_CTRL_B, 8'h01);
    wr(CCU_ADDR_COUNT, 8'h20);
    rd(CCU_ADDR_COUNT, v);
    chk_byte(v, 8'h21);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    // Divide by 8: about ten ticks in eighty clocks
    wr(CCU_ADDR_COUNT, 8'h00);
    wr(CCU_ADDR_CTRL_B, 8'h02);
    repeat (80) @(posedge clk);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    rd(CCU_ADDR_COUNT, v);
    chk_bit(v >= 8'h09 && v <= 8'h0B, 1'b1);
    // Rising, then falling edges of the external input
    for (int s = 7; s >= 6; s--) begin
      wr(CCU_ADDR_COUNT, 8'h00);
      wr(CCU_ADDR_CTRL_B, 8'(s));
      repeat (3) begin
        @(posedge clk);
        ext_count_in <= 1'b1;
        repeat (3) @(posedge clk);
        ext_count_in <= 1'b0;
        repeat (3) @(posedge clk);
      end
      wr(CCU_ADDR_CTRL_B, 8'h00);
      rd(CCU_ADDR_COUNT, v);
      chk_byte(v, 8'h03);
    end
  endtask

  task automatic t_compare;
    wr(CCU_ADDR_CMP_A, 8'h30);
    wr(CCU_ADDR_CMP_B, 8'h31);
    wr(CCU_ADDR_IRQ_EN, 8'h06);
    wr(CCU_ADDR_COUNT, 8'h2C);
    wr(CCU_ADDR_CTRL_B, 8'h01);
    wait_irq(1, 20);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    #1;
    chk_bit(irq_compare_a, 1'b1);
    chk_bit(irq_compare_b, 1'b1);
    rd(CCU_ADDR_FLAGS, v);
    chk_byte(v, 8'h06);
    @(posedge clk);
    irq_ack_compare_a <= 1'b1;
    @(posedge clk);
    irq_ack_compare_a <= 1'b0;
    #1;
    chk_bit(irq_compare_a, 1'b0);
    wr(CCU_ADDR_FLAGS, 8'h04);
    #1;
    chk_bit(irq_compare_b, 1'b0);
    // Overflow at the wrap in normal mode
    wr(CCU_ADDR_IRQ_EN, 8'h01);
    wr(CCU_ADDR_COUNT, 8'hFC);
    wr(CCU_ADDR_CTRL_B, 8'h01);
    wait_irq(0, 12);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    #1;
    chk_bit(irq_overflow, 1'b1);
    @(posedge clk);
    irq_ack_overflow <= 1'b1;
    @(posedge clk);
    irq_ack_overflow <= 1'b0;
    #1;
    chk_bit(irq_overflow, 1'b0);
  endtask

  task automatic t_block;
    wr(CCU_ADDR_CMP_A, 8'h40);
    wr(CCU_ADDR_COUNT, 8'h40);
    repeat (3) @(posedge clk);
    wr(CCU_ADDR_CTRL_B, 8'h01);
    repeat (4) @(posedge clk);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    rd(CCU_ADDR_FLAGS, v);
    chk_byte(v, 8'h00);
    // Clear on compare keeps the count at or below compare A
    wr(CCU_ADDR_CTRL_A, 8'h02);
    wr(CCU_ADDR_CMP_A, 8'h05);
    wr(CCU_ADDR_COUNT, 8'h00);
    wr(CCU_ADDR_CTRL_B, 8'h01);
    repeat (30) @(posedge clk);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    rd(CCU_ADDR_COUNT, v);
    chk_bit(v <= 8'h05, 1'b1);
    // Matches at the top, no overflow without a wrap through FF
    rd(CCU_ADDR_FLAGS, v);
    chk_byte(v, 8'h02);
    wr(CCU_ADDR_FLAGS, 8'h07);
  endtask

  task automatic t_pins;
    wr(CCU_ADDR_CTRL_A, 8'h40);
    @(posedge clk);
    port_data <= 2'b10;
    wave_pin_direction <= 2'b00;
    wr(CCU_ADDR_COUNT, 8'h50);
    wr(CCU_ADDR_CTRL_B, 8'hC0);
    wave_pin_direction <= 2'b11;
    #1;
    chk_byte({6'h00, pin_out}, 8'h03);
    chk_byte({6'h00, pin_oe}, 8'h03);
    rd(CCU_ADDR_FLAGS, v);
    chk_byte(v, 8'h00);
    rd(CCU_ADDR_COUNT, v);
    chk_byte(v, 8'h50);
    wr(CCU_ADDR_CTRL_A, 8'h03);
    #1;
    chk_byte({6'h00, pin_out}, 8'h02);
    // Forced B with no action must have left its output low
    wr(CCU_ADDR_CTRL_A, 8'h73);
    #1;
    chk_byte({6'h00, pin_out}, 8'h01);
    @(posedge clk);
    wave_pin_direction <= 2'b01;
    @(posedge clk);
    #1;
    chk_byte({6'h00, pin_oe}, 8'h01);
  endtask

  task automatic t_buffer;
    wr(CCU_ADDR_CTRL_A, 8'h00);
    wr(CCU_ADDR_CMP_A, 8'h10);
    wr(CCU_ADDR_CTRL_A, 8'h03);
    wr(CCU_ADDR_CMP_A, 8'h20);
    rd(CCU_ADDR_CMP_A, v);
    chk_byte(v, 8'h20);
    wr(CCU_ADDR_FLAGS, 8'h07);
    wr(CCU_ADDR_COUNT, 8'h0C);
    wr(CCU_ADDR_CTRL_B, 8'h01);
    repeat (8) @(posedge clk);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    // Old active value still matches until the top
    rd(CCU_ADDR_FLAGS, v);
    chk_byte(v, 8'h02);
    // Through the top: buffer moves to active, overflow at top
    wr(CCU_ADDR_FLAGS, 8'h07);
    wr(CCU_ADDR_COUNT, 8'hFE);
    wr(CCU_ADDR_CTRL_B, 8'h01);
    repeat (4) @(posedge clk);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    rd(CCU_ADDR_FLAGS, v);
    chk_byte(v, 8'h01);
    wr(CCU_ADDR_CTRL_A, 8'h00);
    rd(CCU_ADDR_CMP_A, v);
    chk_byte(v, 8'h20);
    // Phase correct turns at the top and counts down
    wr(CCU_ADDR_CTRL_A, 8'h01);
    wr(CCU_ADDR_COUNT, 8'hFD);
    wr(CCU_ADDR_CTRL_B, 8'h01);
    repeat (3) @(posedge clk);
    wr(CCU_ADDR_CTRL_B, 8'h00);
    rd(CCU_ADDR_COUNT, v);
    chk_byte(v, 8'hFC);
  endtask

  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #200000;
    errors++;
    stop_test;
  end

  initial begin
    errors = 0;
    compares = 0;
    reset_n = 1'b0;
    bus = '0;
    ext_count_in = 1'b0;
    irq_ack_overflow = 1'b0;
    irq_ack_compare_a = 1'b0;
    irq_ack_compare_b = 1'b0;
    port_data = 2'b01;
    wave_pin_direction = 2'b10;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_count;
    t_compare;
    t_block;
    t_pins;
    t_buffer;
    stop_test;
  end
endmodule
